//--- inc/vsw_pkg.sv
/*
 * constants, command codes, reset values and carrier types for the serial
 * command receiver and display ram writer of a 5x7 dot, 16-digit display.
 * assumes one core clock; the serial data, shift clock and select pins are asynchronous to it.
 */
package vsw_pkg;

    // ****************************************************************
    // command codes (byte bits 7:4)
    // ****************************************************************
    localparam logic [3:0] CMD_CHAR   = 4'h1;
    localparam logic [3:0] CMD_PAT    = 4'h2;
    localparam logic [3:0] CMD_SYM    = 4'h3;
    localparam logic [3:0] CMD_PORT   = 4'h4;
    localparam logic [3:0] CMD_DUTY   = 4'h5;
    localparam logic [3:0] CMD_DIGITS = 4'h6;
    localparam logic [3:0] CMD_LIGHTS = 4'h7;

    // ****************************************************************
    // sizes, counts and reset values
    // ****************************************************************
    localparam int         NUM_DIGITS     = 16;
    localparam int         PAT_ENTRIES    = 8;
    localparam int         PAT_DOTS       = 35;
    localparam int         PAT_ROWS       = 7;
    localparam int         PAT_COLS       = 5;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam logic [2:0] LAST_COL       = 3'h4;
    localparam logic [7:0] ROM_FIRST_CODE = 8'h08;
    localparam logic [3:0] FULL_SCAN_LAST = 4'hf;
    localparam logic [3:0] PART_SCAN_BASE = 4'h7;
    localparam logic [3:0] ADDR4_RST      = 4'h0;
    localparam logic [2:0] ADDR3_RST      = 3'h0;
    localparam logic [2:0] DUTY_RST       = 3'h0;
    localparam logic [2:0] DIGITS_RST     = 3'h0;
    localparam logic [1:0] GP_RST         = 2'h0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_CMD  = 2'b00,
        MODE_CHAR = 2'b01,
        MODE_PAT  = 2'b10,
        MODE_SYM  = 2'b11
    } vsw_mode_t;

    typedef struct packed {
        logic       frame;
        logic       valid;
        logic [7:0] data;
    } vsw_byte_t;

    typedef struct packed {
        logic [1:0] gp;
        logic [2:0] duty;
        logic [2:0] digits;
        logic       lights_on;
        logic       lights_off;
    } vsw_settings_t;

endpackage : vsw_pkg

//--- tb/test_vsw_ram_writer.sv
/* self-checking bench for the display ram writer driven by a host model.
   assumes a 200 mhz core clock and an 80 ns host shift clock. */
module test_vsw_ram_writer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk    = 1'b0;
    logic        i_resetn      = 1'b0;
    logic [3:0]  i_scan_digit  = 4'h0;
    logic [34:0] i_rom_pattern = 35'h0;
    logic        sdi, sck_n, cs_n, sym1, sym2, gp1, gp2;
    logic [7:0]  rom_code, b;
    logic [34:0] seg;
    logic [15:0] grid;
    logic [2:0]  duty, digs;
    logic [7:0]  char_m [16];
    logic [34:0] pat_m [8];
    logic [1:0]  sym_m [16];
    logic [2:0]  duty_m = 3'h0, dig_m = 3'h0;
    logic [1:0]  gp_m = 2'h0, lit_m = 2'h1;
    logic [3:0]  a;
    logic [7:0]  q [$];
    int          seed = 32'h2839, fails = 0, samples_checked = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    vsw_host_model i_host (.o_serial_data_in(sdi), .o_shift_clock_n(sck_n),
        .o_chip_select_n(cs_n));
    vsw_ram_writer i_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_serial_data_in(sdi), .i_shift_clock_n(sck_n), .i_chip_select_n(cs_n),
        .i_scan_digit(i_scan_digit), .i_rom_pattern(i_rom_pattern), .o_rom_code(rom_code),
        .o_segment_outputs(seg), .o_symbol_output_1(sym1), .o_symbol_output_2(sym2),
        .o_grid_outputs(grid), .o_gp_out_1(gp1), .o_gp_out_2(gp2),
        .o_duty_bits(duty), .o_digit_count_bits(digs));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [34:0] seg_exp(input int d);
        if (lit_m[1]) return {35{1'b1}};
        if (lit_m[0]) return 35'h0;
        return (char_m[d] < 8'h08) ? pat_m[char_m[d][2:0]] : i_rom_pattern;
    endfunction : seg_exp
    task automatic go(input int nlast);
        @(posedge i_core_clk);
        #1 i_host.frame(q, nlast);
        q.delete();
    endtask : go
    task automatic show(input int d, input bit full);
        @(posedge i_core_clk);
        #1 i_scan_digit = d[3:0];
        i_rom_pattern = 35'({$random(seed), $random(seed)});
        repeat (4) @(posedge i_core_clk);
        #1;
        if (full) check(rom_code, char_m[d]);
        check(seg, seg_exp(d));
        check({sym2, sym1}, lit_m[1] ? 2'h3 : lit_m[0] ? 2'h0 : sym_m[d]);
        check(grid, (dig_m == 3'h0 || d <= 7 + dig_m) ? 16'h1 << d : 16'h0);
        check({gp2, gp1, duty, digs}, {gp_m, duty_m, dig_m});
    endtask : show
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #300000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge i_core_clk);
        #1 i_resetn = 1'b1;
        for (int d = 0; d < 16; d++) show(d, 1'b0);
        gp_m   = 2'($random(seed));
        duty_m = 3'($random(seed));
        lit_m  = 2'h0;
        q = '{8'h70, {6'h10, gp_m}, {5'h0a, duty_m}};
        go(8);
        q.push_back(8'h20);
        for (int e = 0; e < 8; e++) begin
            for (int c = 0; c < 5; c++) begin
                b = 8'($random(seed));
                q.push_back(b);
                for (int r = 0; r < 7; r++) pat_m[e][5 * r + c] = b[r];
            end
        end
        go(8);
        a = 4'($random(seed));
        for (int k = 0; k < 2; k++) begin
            q.push_back(k ? 8'h10 : {4'h1, a});
            for (int d = k ? 0 : a; d < (k ? a : 16); d++) begin
                b = 8'($random(seed));
                char_m[d] = b[3] ? b : {5'h0, b[2:0]};
                q.push_back(char_m[d]);
            end
            go(8);
        end
        q.push_back(8'h30);
        for (int d = 0; d < 16; d++) begin
            b = 8'($random(seed));
            sym_m[d] = b[1:0];
            q.push_back(b);
        end
        go(8);
        dig_m = 3'($unsigned($random(seed)) % 7 + 1);
        q.push_back({5'h0c, dig_m});
        go(8);
        for (int d = 0; d < 16; d++) show(d, 1'b1);
        for (int l = 3; l >= 0; l--) begin
            lit_m = 2'(l);
            q.push_back({6'h1c, lit_m});
            go(8);
            show(l * 5, 1'b1);
        end
        for (int c = 8; c <= 16; c++) q.push_back({4'(c), 4'h5});
        q.push_back({5'h0a, ~duty_m});
        go(5);
        show(3, 1'b1);
        duty_m = duty_m + 3'h3;
        q.push_back({5'h0a, duty_m});
        go(8);
        show(9, 1'b1);
        @(posedge i_core_clk);
        #1 i_resetn = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1 i_resetn = 1'b1;
        {gp_m, duty_m, dig_m, lit_m} = {2'h0, 3'h0, 3'h0, 2'h1};
        show(4, 1'b0);
        report_and_stop();
    end
endmodule : test_vsw_ram_writer

//--- tb/vsw_host_model.sv
/* host model: drives select, shift clock and serial data of the receiver.
   assumes the bench calls its frame task just after a core clock edge. */
module vsw_host_model (
    output logic o_serial_data_in,
    output logic o_shift_clock_n,
    output logic o_chip_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_serial_data_in = 1'b0;
        o_shift_clock_n  = 1'b1;
        o_chip_select_n  = 1'b1;
    end
    // n bits lsb first; clock idles high; data inverted once hold has run out
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            o_shift_clock_n  = 1'b0;
            o_serial_data_in = b[i];
            #40 o_shift_clock_n = 1'b1;
            #40;
        end
        o_serial_data_in = ~o_serial_data_in;
        #320;
    endtask : send
    // one select frame; the last byte may be cut short
    task automatic frame(input logic [7:0] q [$], input int nlast);
        o_chip_select_n = 1'b0;
        #260;
        foreach (q[i]) send(q[i], (i == q.size() - 1) ? nlast : 8);
        o_chip_select_n = 1'b1;
        #260;
    endtask : frame
endmodule : vsw_host_model

//--- verilog/vsw_ram_writer.sv
/*
 * command decoder, display rams, settings and per-digit output stage.
 * assumes an outside scan sequencer drives i_scan_digit on i_core_clk and
 * a combinational fixed pattern rom answers o_rom_code on i_rom_pattern.
 */
module vsw_ram_writer (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_serial_data_in,
    input  wire logic        i_shift_clock_n,
    input  wire logic        i_chip_select_n,
    input  wire logic [3:0]  i_scan_digit,
    input  wire logic [34:0] i_rom_pattern,
    output logic      [7:0]  o_rom_code,
    output logic      [34:0] o_segment_outputs,
    output logic             o_symbol_output_1,
    output logic             o_symbol_output_2,
    output logic      [15:0] o_grid_outputs,
    output logic             o_gp_out_1,
    output logic             o_gp_out_2,
    output logic      [2:0]  o_duty_bits,
    output logic      [2:0]  o_digit_count_bits
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [3:0] vsw_last_grid(input logic [2:0] cnt);
        if (cnt == 3'h0) begin
            return vsw_pkg::FULL_SCAN_LAST;
        end
        return vsw_pkg::PART_SCAN_BASE + {1'b0, cnt};
    endfunction : vsw_last_grid

    function automatic logic [34:0] vsw_col_merge(input logic [34:0] old,
                                                  input logic [2:0]  col,
                                                  input logic [6:0]  rows);
        logic [34:0] r;
        r = old;
        for (int k = 0; k < vsw_pkg::PAT_ROWS; k++) begin
            for (int c = 0; c < vsw_pkg::PAT_COLS; c++) begin
                if (col == 3'(c)) begin
                    r[vsw_pkg::PAT_COLS * k + c] = rows[k];
                end
            end
        end
        return r;
    endfunction : vsw_col_merge

    // ****************************************************************
    // serial receiver
    // ****************************************************************
    vsw_pkg::vsw_byte_t rx;

    vsw_serial_rx u_rx (
        .i_core_clk      (i_core_clk),
        .i_resetn        (i_resetn),
        .i_serial_data_in(i_serial_data_in),
        .i_shift_clock_n (i_shift_clock_n),
        .i_chip_select_n (i_chip_select_n),
        .o_rx            (rx)
    );

    // ****************************************************************
    // command decode and pointers
    // ****************************************************************
    vsw_pkg::vsw_mode_t     mode;
    vsw_pkg::vsw_mode_t     next_mode;
    logic [3:0]             char_addr;
    logic [3:0]             next_char_addr;
    logic [2:0]             pat_addr;
    logic [2:0]             next_pat_addr;
    logic [2:0]             pat_col;
    logic [2:0]             next_pat_col;
    logic [3:0]             sym_addr;
    logic [3:0]             next_sym_addr;
    vsw_pkg::vsw_settings_t set;
    vsw_pkg::vsw_settings_t next_set;
    logic                   char_we;
    logic                   pat_we;
    logic                   sym_we;
    logic [34:0]            pat_wdata;
    logic [7:0]             char_ram [vsw_pkg::NUM_DIGITS];
    logic [34:0]            pat_ram  [vsw_pkg::PAT_ENTRIES];
    logic [1:0]             sym_ram  [vsw_pkg::NUM_DIGITS];

    always_comb begin
        next_mode      = mode;
        next_char_addr = char_addr;
        next_pat_addr  = pat_addr;
        next_pat_col   = pat_col;
        next_sym_addr  = sym_addr;
        next_set       = set;
        char_we        = 1'b0;
        pat_we         = 1'b0;
        sym_we         = 1'b0;
        pat_wdata      = vsw_col_merge(pat_ram[pat_addr], pat_col, rx.data[6:0]);
        if (!rx.frame) begin
            next_mode = vsw_pkg::MODE_CMD;
        end else if (rx.valid) begin
            unique case (mode)
                vsw_pkg::MODE_CMD: begin
                    case (rx.data[7:4])
                        vsw_pkg::CMD_CHAR: begin
                            next_mode      = vsw_pkg::MODE_CHAR;
                            next_char_addr = rx.data[3:0];
                        end
                        vsw_pkg::CMD_PAT: begin
                            next_mode     = vsw_pkg::MODE_PAT;
                            next_pat_addr = rx.data[2:0];
                            next_pat_col  = 3'h0;
                        end
                        vsw_pkg::CMD_SYM: begin
                            next_mode     = vsw_pkg::MODE_SYM;
                            next_sym_addr = rx.data[3:0];
                        end
                        vsw_pkg::CMD_PORT: begin
                            next_set.gp = rx.data[1:0];
                        end
                        vsw_pkg::CMD_DUTY: begin
                            next_set.duty = rx.data[2:0];
                        end
                        vsw_pkg::CMD_DIGITS: begin
                            next_set.digits = rx.data[2:0];
                        end
                        vsw_pkg::CMD_LIGHTS: begin
                            next_set.lights_off = rx.data[0];
                            next_set.lights_on  = rx.data[1];
                        end
                        default: begin
                            next_mode = vsw_pkg::MODE_CMD;
                        end
                    endcase
                end
                vsw_pkg::MODE_CHAR: begin
                    char_we        = 1'b1;
                    next_char_addr = char_addr + 4'h1;
                end
                vsw_pkg::MODE_PAT: begin
                    pat_we = 1'b1;
                    if (pat_col == vsw_pkg::LAST_COL) begin
                        next_pat_col  = 3'h0;
                        next_pat_addr = pat_addr + 3'h1;
                    end else begin
                        next_pat_col = pat_col + 3'h1;
                    end
                end
                vsw_pkg::MODE_SYM: begin
                    sym_we        = 1'b1;
                    next_sym_addr = sym_addr + 4'h1;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode      <= vsw_pkg::MODE_CMD;
            char_addr <= vsw_pkg::ADDR4_RST;
            pat_addr  <= vsw_pkg::ADDR3_RST;
            pat_col   <= 3'h0;
            sym_addr  <= vsw_pkg::ADDR4_RST;
            set       <= '{gp: vsw_pkg::GP_RST, duty: vsw_pkg::DUTY_RST,
                           digits: vsw_pkg::DIGITS_RST, lights_on: 1'b0,
                           lights_off: 1'b1};
        end else begin
            mode      <= next_mode;
            char_addr <= next_char_addr;
            pat_addr  <= next_pat_addr;
            pat_col   <= next_pat_col;
            sym_addr  <= next_sym_addr;
            set       <= next_set;
        end
    end

    // ****************************************************************
    // display rams (contents not reset)
    // ****************************************************************
    always_ff @(posedge i_core_clk) begin
        if (char_we) begin
            char_ram[char_addr] <= rx.data;
        end
        if (pat_we) begin
            pat_ram[pat_addr] <= pat_wdata;
        end
        if (sym_we) begin
            sym_ram[sym_addr] <= rx.data[1:0];
        end
    end

    // ****************************************************************
    // output stage
    // ****************************************************************
    logic [3:0]  digit_q;
    logic [3:0]  next_digit_q;
    logic [7:0]  next_rom_code;
    logic [34:0] next_seg;
    logic        next_sym1;
    logic        next_sym2;
    logic [15:0] next_grid;
    logic [34:0] pattern;
    logic [15:0] grid_sel;
    logic [3:0]  last_grid;

    assign last_grid = vsw_last_grid(set.digits);

    for (genvar g = 0; g < vsw_pkg::NUM_DIGITS; g++) begin : g_grid
        assign grid_sel[g] = digit_q == 4'(g) && digit_q <= last_grid;
    end

    always_comb begin
        next_digit_q  = i_scan_digit;
        next_rom_code = char_ram[i_scan_digit];
        if (o_rom_code < vsw_pkg::ROM_FIRST_CODE) begin
            pattern = pat_ram[o_rom_code[2:0]];
        end else begin
            pattern = i_rom_pattern;
        end
        next_seg  = pattern;
        next_sym1 = sym_ram[digit_q][0];
        next_sym2 = sym_ram[digit_q][1];
        if (set.lights_on) begin
            next_seg  = '1;
            next_sym1 = 1'b1;
            next_sym2 = 1'b1;
        end else if (set.lights_off) begin
            next_seg  = '0;
            next_sym1 = 1'b0;
            next_sym2 = 1'b0;
        end
        next_grid = grid_sel;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            digit_q            <= 4'h0;
            o_rom_code         <= 8'h00;
            o_segment_outputs  <= '0;
            o_symbol_output_1  <= 1'b0;
            o_symbol_output_2  <= 1'b0;
            o_grid_outputs     <= 16'h0000;
            o_gp_out_1         <= 1'b0;
            o_gp_out_2         <= 1'b0;
            o_duty_bits        <= vsw_pkg::DUTY_RST;
            o_digit_count_bits <= vsw_pkg::DIGITS_RST;
        end else begin
            digit_q            <= next_digit_q;
            o_rom_code         <= next_rom_code;
            o_segment_outputs  <= next_seg;
            o_symbol_output_1  <= next_sym1;
            o_symbol_output_2  <= next_sym2;
            o_grid_outputs     <= next_grid;
            o_gp_out_1         <= set.gp[0];
            o_gp_out_2         <= set.gp[1];
            o_duty_bits        <= set.duty;
            o_digit_count_bits <= set.digits;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_char_addr_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_CHAR
        |=> char_addr == $past(char_addr) + 4'h1 && mode == vsw_pkg::MODE_CHAR)
        else $error("char code address did not advance");
    a_pat_entry_wrap: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_PAT && pat_col == 3'h4
        |=> pat_col == 3'h0 && pat_addr == $past(pat_addr) + 3'h1)
        else $error("pattern address did not advance after fifth column");
    a_sym_addr_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_SYM
        |=> sym_addr == $past(sym_addr) + 4'h1)
        else $error("symbol address did not advance");
    a_frame_to_cmd: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !rx.frame |=> mode == vsw_pkg::MODE_CMD)
        else $error("deselect left a data mode open");
    a_duty_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_CMD && rx.data[7:4] == 4'h5
        |=> ##1 o_duty_bits == $past(rx.data[2:0], 2))
        else $error("duty command not applied");
    a_port_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_CMD && rx.data[7:4] == 4'h4
        |=> ##1 {o_gp_out_2, o_gp_out_1} == $past(rx.data[1:0], 2))
        else $error("port command not applied");
    a_lights_on_wins: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        set.lights_on |=> o_segment_outputs == '1 && o_symbol_output_1 && o_symbol_output_2)
        else $error("all lights on not forced high");
    a_lights_off_low: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        set.lights_off && !set.lights_on
        |=> o_segment_outputs == '0 && !o_symbol_output_1 && !o_symbol_output_2)
        else $error("lights off not forced low");
    a_grid_limit: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        digit_q > vsw_last_grid(set.digits) |=> o_grid_outputs == 16'h0000)
        else $error("grid beyond digit count driven");
    a_other_cmd_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_CMD && (rx.data[7:4] == 4'h0
        || rx.data[7:4] > 4'h7) |=> set == $past(set) && mode == vsw_pkg::MODE_CMD)
        else $error("unknown command changed state");

    logic cmd_take;

    assign cmd_take = rx.frame && rx.valid && mode == vsw_pkg::MODE_CMD;

    a_char_cmd_enter: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cmd_take && rx.data[7:4] == vsw_pkg::CMD_CHAR
        |=> mode == vsw_pkg::MODE_CHAR && char_addr == $past(rx.data[3:0]))
        else $error("char code command did not open char mode");
    a_pat_cmd_enter: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cmd_take && rx.data[7:4] == vsw_pkg::CMD_PAT
        |=> mode == vsw_pkg::MODE_PAT && pat_addr == $past(rx.data[2:0]) && pat_col == 3'h0)
        else $error("pattern command did not open pattern mode");
    a_sym_cmd_enter: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cmd_take && rx.data[7:4] == vsw_pkg::CMD_SYM
        |=> mode == vsw_pkg::MODE_SYM && sym_addr == $past(rx.data[3:0]))
        else $error("symbol command did not open symbol mode");
    a_pat_col_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        rx.frame && rx.valid && mode == vsw_pkg::MODE_PAT && pat_col != vsw_pkg::LAST_COL
        |=> pat_col == $past(pat_col) + 3'h1 && pat_addr == $past(pat_addr))
        else $error("pattern column did not step");
    a_char_store: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        char_we |=> char_ram[$past(char_addr)] == $past(rx.data))
        else $error("char code byte not stored");
    a_sym_store: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        sym_we |=> sym_ram[$past(sym_addr)] == $past(rx.data[1:0]))
        else $error("symbol bits not stored");
    a_grid_select: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        digit_q <= vsw_last_grid(set.digits) |=> o_grid_outputs == 16'h0001 << $past(digit_q))
        else $error("grid output does not match scanned digit");
    a_digits_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cmd_take && rx.data[7:4] == vsw_pkg::CMD_DIGITS
        |=> ##1 o_digit_count_bits == $past(rx.data[2:0], 2))
        else $error("digit count command not applied");
    a_lights_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cmd_take && rx.data[7:4] == vsw_pkg::CMD_LIGHTS
        |=> set.lights_off == $past(rx.data[0]) && set.lights_on == $past(rx.data[1]))
        else $error("all lights command not applied");
    a_lights_keep_port: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        cmd_take && rx.data[7:4] == vsw_pkg::CMD_LIGHTS |=> set.gp == $past(set.gp))
        else $error("all lights command changed the general outputs");

endmodule : vsw_ram_writer

//--- verilog/vsw_serial_rx.sv
/*
 * serial byte receiver: synchronises data, shift clock and select pins,
 * finds shift clock rising edges and assembles bytes lsb first.
 * assumes the pins are asynchronous to i_core_clk and far slower.
 */
module vsw_serial_rx (
    input  wire logic          i_core_clk,
    input  wire logic          i_resetn,
    input  wire logic          i_serial_data_in,
    input  wire logic          i_shift_clock_n,
    input  wire logic          i_chip_select_n,
    output vsw_pkg::vsw_byte_t o_rx
);

    // ****************************************************************
    // synchroniser and shift state
    // ****************************************************************
    logic [2:0]         sync1;
    logic [2:0]         sync2;
    logic               clk_prev;
    logic [7:0]         shift;
    logic [2:0]         count;
    logic [2:0]         next_sync1;
    logic [2:0]         next_sync2;
    logic               next_clk_prev;
    logic [7:0]         next_shift;
    logic [2:0]         next_count;
    vsw_pkg::vsw_byte_t next_rx;
    logic               rise;

    always_comb begin
        next_sync1    = {i_chip_select_n, i_shift_clock_n, i_serial_data_in};
        next_sync2    = sync1;
        next_clk_prev = sync2[1];
        rise          = sync2[1] & ~clk_prev;
        next_shift    = shift;
        next_count    = count;
        next_rx       = '{frame: ~sync2[2], valid: 1'b0, data: o_rx.data};
        if (sync2[2]) begin
            next_count = 3'h0;
        end else if (rise) begin
            next_shift = {sync2[0], shift[7:1]};
            next_count = count + 3'h1;
            if (count == vsw_pkg::LAST_BIT) begin
                next_rx.valid = 1'b1;
                next_rx.data  = {sync2[0], shift[7:1]};
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1    <= 3'h7;
            sync2    <= 3'h7;
            clk_prev <= 1'b1;
            shift    <= 8'h00;
            count    <= 3'h0;
            o_rx     <= '0;
        end else begin
            sync1    <= next_sync1;
            sync2    <= next_sync2;
            clk_prev <= next_clk_prev;
            shift    <= next_shift;
            count    <= next_count;
            o_rx     <= next_rx;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_byte_after_eight: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_rx.valid |-> $past(count) == 3'h7 && $past(rise) && count == 3'h0)
        else $error("byte strobe without eighth bit");
    a_deselect_clears: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        sync2[2] |=> count == 3'h0 && !o_rx.valid && !o_rx.frame)
        else $error("deselect did not drop partial byte");
    a_count_on_edge: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (count != $past(count)) && count != 3'h0 |-> $past(rise))
        else $error("bit counted without a rising shift edge");

endmodule : vsw_serial_rx
